// >>> pso_power_ctrl.sv
// Top of the power and serial option control block with its APB slave.
// Assumes APB master on mclk, cold_reset pulse from the power-on detector.
`timescale 1ns/10ps
module pso_power_ctrl (
    input  wire logic                     mclk,             // Core clock, 250 MHz
    input  wire logic                     reset,            // Warm reset, async high
    input  wire logic                     cold_reset,       // Power-on reset, async high
    input  wire logic [pso_pkg::PSO_AW-1:0] paddr,          // APB address
    input  wire logic                     psel,             // APB select
    input  wire logic                     penable,          // APB enable
    input  wire logic                     pwrite,           // APB direction
    input  wire logic [pso_pkg::PSO_DW-1:0] pwdata,         // APB write data
    output logic      [pso_pkg::PSO_DW-1:0] prdata,         // APB read data
    output logic                          pready,           // APB ready
    output logic                          pslverr,          // APB error
    input  wire logic                     stop_bit_invalid, // Receiver bad stop pulse
    input  wire logic                     wake_event,       // Wake from power-down
    output logic                          power_down,       // Power-down state
    output logic                          baud_rate_x2,     // UART runs double rate
    output logic      [7:0]               serial_control,   // Serial control, bit7 mode
    output logic                          framing_error,    // Framing flag
    output logic                          irq               // Interrupt level
);
    import pso_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic       baud_double;            // Doubling bit
    logic       frame_error_select;     // Bit 7 view select
    logic [1:0] gp_flags;               // General flags
    logic       power_off_flag;         // Cold start flag
    logic [7:0] sc;                     // Serial control, bit7 is mode bit 0
    logic       framing_flag;           // Framing error flag
    logic       next_baud_double;       // Next doubling
    logic       next_frame_error_select;// Next select
    logic [1:0] next_gp_flags;          // Next flags
    logic       next_power_off_flag;    // Next cold flag
    logic [7:0] next_sc;                // Next serial control
    logic       next_framing_flag;      // Next framing flag
    logic       next_power_down;        // Next power-down
    logic       next_baud_rate_x2;      // Next double rate
    logic [31:0] next_prdata;           // Next read data
    logic       next_pready;            // Next ready
    logic       next_pslverr;           // Next error
    logic       take;                   // Access phase first cycle
    logic       commit;                 // Write takes effect
    logic       wr_pwr;                 // Power control write
    logic       wr_ser;                 // Serial control write
    logic       mapped;                 // Address decodes
    logic [7:0] pwr_view;               // Power control read value
    logic [7:0] ser_view;               // Serial control read value
    pso_irq_if  irqc ();                // Interrupt bank link

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    always_comb begin
        take   = psel && penable && !pready;
        commit = psel && penable && pready && pwrite;
        mapped = (paddr == PSO_PWR_CTRL) || (paddr == PSO_SER_CTRL) ||
                 (paddr == PSO_IRQ_STATUS) || (paddr == PSO_IRQ_MASK);
        wr_pwr = commit && (paddr == PSO_PWR_CTRL);
        wr_ser = commit && (paddr == PSO_SER_CTRL);
    end

    // Read views; reserved bits read zero
    always_comb begin
        pwr_view = 8'h00;
        pwr_view[PSO_BAUD_DBL] = baud_double;
        pwr_view[PSO_FRAME_SEL] = frame_error_select;
        pwr_view[PSO_PWR_OFF] = power_off_flag;
        pwr_view[PSO_GP_HI:PSO_GP_LO] = gp_flags;
        pwr_view[PSO_PD] = power_down;
        ser_view = sc;
        ser_view[PSO_SC_BIT7] = frame_error_select ? framing_flag : sc[PSO_SC_BIT7];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb begin
        next_baud_double        = baud_double;
        next_frame_error_select = frame_error_select;
        next_gp_flags           = gp_flags;
        next_sc                 = sc;
        next_framing_flag       = framing_flag;
        next_power_down         = power_down;
        if (wr_pwr) begin
            next_baud_double        = pwdata[PSO_BAUD_DBL];
            next_frame_error_select = pwdata[PSO_FRAME_SEL];
            next_gp_flags           = pwdata[PSO_GP_HI:PSO_GP_LO];
            if (pwdata[PSO_PD]) begin
                next_power_down = 1'b1;
            end
        end
        if (wake_event) begin
            next_power_down = 1'b0; // Wake clears power-down
        end
        if (wr_ser) begin
            next_sc[6:0] = pwdata[6:0];
            if (frame_error_select) begin
                next_framing_flag = pwdata[PSO_SC_BIT7];
            end else begin
                next_sc[PSO_SC_BIT7] = pwdata[PSO_SC_BIT7];
            end
        end
        if (stop_bit_invalid) begin
            next_framing_flag = 1'b1;
        end
        next_baud_rate_x2 = next_baud_double && (next_sc[7:6] != PSO_MODE_SHIFT);
    end

    // Warm reset domain
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            baud_double        <= PSO_PWR_RST[PSO_BAUD_DBL];
            frame_error_select <= PSO_PWR_RST[PSO_FRAME_SEL];
            gp_flags           <= PSO_PWR_RST[PSO_GP_HI:PSO_GP_LO];
            power_down         <= PSO_PWR_RST[PSO_PD];
            sc                 <= PSO_SER_RST;
            framing_flag       <= 1'b0;
            baud_rate_x2       <= 1'b0;
        end else begin
            baud_double        <= next_baud_double;
            frame_error_select <= next_frame_error_select;
            gp_flags           <= next_gp_flags;
            power_down         <= next_power_down;
            sc                 <= next_sc;
            framing_flag       <= next_framing_flag;
            baud_rate_x2       <= next_baud_rate_x2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-off flag: cold reset only, warm reset ignored
    always_comb begin
        next_power_off_flag = wr_pwr ? pwdata[PSO_PWR_OFF] : power_off_flag;
    end

    always_ff @(posedge mclk or posedge cold_reset) begin
        if (cold_reset) begin
            power_off_flag <= PSO_OFF_COLD;
        end else begin
            power_off_flag <= next_power_off_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer, one wait state
    always_comb begin
        next_pready  = take;
        next_pslverr = take && !mapped;
        next_prdata  = prdata;
        if (take) begin
            case (paddr)
                PSO_PWR_CTRL:   next_prdata = {24'h000000, pwr_view};
                PSO_SER_CTRL:   next_prdata = {24'h000000, ser_view};
                PSO_IRQ_STATUS: next_prdata = {30'h0, irqc.status};
                PSO_IRQ_MASK:   next_prdata = {30'h0, irqc.mask};
                default:        next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt bank
    always_comb begin
        irqc.events                = 2'h0;
        irqc.events[PSO_IRQ_FRAME] = stop_bit_invalid;
        irqc.events[PSO_IRQ_PD]    = next_power_down && !power_down;
        irqc.wr_status             = commit && (paddr == PSO_IRQ_STATUS);
        irqc.wr_mask               = commit && (paddr == PSO_IRQ_MASK);
        irqc.wdata                 = pwdata[1:0];
    end

    pso_irq_bank u_irq (
        .mclk  (mclk),
        .reset (reset),
        .ib    (irqc.bank)
    );

    // Output aliases of flip-flops
    assign irq            = irqc.irq;
    assign serial_control = sc;
    assign framing_error  = framing_flag;

    ////////////////////////////////////////////////////////////////////////////////
    a_pd_entry: assert property (@(posedge mclk) disable iff (reset)
        (wr_pwr && pwdata[PSO_PD] && !wake_event) |=> power_down)
        else $error("power-down not entered");
    a_baud_double: assert property (@(posedge mclk) disable iff (reset)
        baud_rate_x2 == (baud_double && (sc[7:6] != PSO_MODE_SHIFT)))
        else $error("double rate wrong");
    a_bit7_view: assert property (@(posedge mclk) disable iff (reset)
        (take && paddr == PSO_SER_CTRL) |=>
        prdata[7] == ($past(frame_error_select) ? $past(framing_flag) : $past(sc[7])))
        else $error("bit 7 view wrong");
    a_framing_set: assert property (@(posedge mclk) disable iff (reset)
        stop_bit_invalid |=> framing_flag) else $error("framing flag not set");
    a_off_flag_hold: assert property (@(posedge mclk) disable iff (cold_reset)
        !wr_pwr |=> power_off_flag == $past(power_off_flag))
        else $error("power-off flag changed");
    a_off_flag_write: assert property (@(posedge mclk) disable iff (cold_reset || reset)
        wr_pwr |=> power_off_flag == $past(pwdata[PSO_PWR_OFF]))
        else $error("power-off flag write lost");
    a_gp_store: assert property (@(posedge mclk) disable iff (reset)
        wr_pwr |=> gp_flags == $past(pwdata[PSO_GP_HI:PSO_GP_LO]))
        else $error("general flags write lost");
    a_apb_ready: assert property (@(posedge mclk) disable iff (reset)
        take |=> pready ##1 !pready) else $error("ready timing wrong");
    c_pd_entry: cover property (@(posedge mclk) disable iff (reset) $rose(power_down));
    c_frame_read: cover property (@(posedge mclk) disable iff (reset)
        take && paddr == PSO_SER_CTRL && frame_error_select && framing_flag);
    c_irq: cover property (@(posedge mclk) disable iff (reset) $rose(irq));
endmodule

// >>> pso_pkg.sv
// Constants of the power and serial option control block: register map, fields, resets.
// Assumes a 32-bit APB slave port with word aligned registers.
package pso_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int          PSO_AW          = 12;         // APB address width
    localparam int          PSO_DW          = 32;         // APB data width
    localparam int          PSO_NIRQ        = 2;          // Interrupt source count
    // Register byte addresses
    localparam logic [11:0] PSO_PWR_CTRL    = 12'h000;    // Power and serial option control
    localparam logic [11:0] PSO_SER_CTRL    = 12'h004;    // Serial control register
    localparam logic [11:0] PSO_IRQ_STATUS  = 12'h008;    // Sticky events, write one clears
    localparam logic [11:0] PSO_IRQ_MASK    = 12'h00c;    // Interrupt enables
    // Power control field positions
    localparam int          PSO_BAUD_DBL    = 7;          // Baud doubling
    localparam int          PSO_FRAME_SEL   = 6;          // Frame error select
    localparam int          PSO_PWR_OFF     = 4;          // Power-off flag
    localparam int          PSO_GP_HI       = 3;          // General flag high bit
    localparam int          PSO_GP_LO       = 2;          // General flag low bit
    localparam int          PSO_PD          = 1;          // Power-down request
    // Serial control field position
    localparam int          PSO_SC_BIT7     = 7;          // Mode bit 0 or framing flag
    // Interrupt bit positions
    localparam int          PSO_IRQ_FRAME   = 0;          // Framing error seen
    localparam int          PSO_IRQ_PD      = 1;          // Power-down entered
    // Reset values
    localparam logic [7:0]  PSO_PWR_RST     = 8'h00;      // Warm reset of control bits
    localparam logic [7:0]  PSO_SER_RST     = 8'h00;      // Serial control reset
    localparam logic        PSO_OFF_COLD    = 1'h1;       // Power-off flag at cold start
    localparam logic [1:0]  PSO_IRQ_RST     = 2'h0;       // Status and mask reset
    localparam logic [1:0]  PSO_MODE_SHIFT  = 2'h0;       // Serial mode 0
endpackage

// >>> pso_irq_if.sv
// Interface between the control core and the interrupt bank.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
interface pso_irq_if;
    logic [1:0] events;     // Event pulses
    logic       wr_status;  // Write-one-clear strobe
    logic       wr_mask;    // Mask write strobe
    logic [1:0] wdata;      // Write data
    logic [1:0] status;     // Sticky status
    logic [1:0] mask;       // Mask value
    logic       irq;        // Interrupt level
    modport bank (input events, wr_status, wr_mask, wdata, output status, mask, irq);
    modport core (output events, wr_status, wr_mask, wdata, input status, mask, irq);
endinterface

// >>> pso_irq_bank.sv
// Sticky interrupt status, mask and registered interrupt level.
// Assumes strobes are one-cycle pulses on mclk.
`timescale 1ns/10ps
module pso_irq_bank (
    input  wire logic mclk,   // Core clock
    input  wire logic reset,  // Async warm reset
    pso_irq_if.bank   ib      // Core side
);
    import pso_pkg::*;
    logic [1:0] status;       // Sticky bits
    logic [1:0] mask;         // Enables
    logic       irq;          // Output level
    logic [1:0] next_status;  // Next sticky bits
    logic [1:0] next_mask;    // Next enables
    logic       next_irq;     // Next level
    ////////////////////////////////////////////////////////////////////////////////
    // Set wins over clear in the same cycle
    always_comb begin
        next_status = status;
        if (ib.wr_status) begin
            next_status = status & ~ib.wdata;
        end
        next_status = next_status | ib.events;
        next_mask   = ib.wr_mask ? ib.wdata : mask;
        next_irq    = |(next_status & next_mask);
    end
    // Register stage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            status <= PSO_IRQ_RST;
            mask   <= PSO_IRQ_RST;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            mask   <= next_mask;
            irq    <= next_irq;
        end
    end
    assign ib.status = status;
    assign ib.mask   = mask;
    assign ib.irq    = irq;
    ////////////////////////////////////////////////////////////////////////////////
    a_irq_level: assert property (@(posedge mclk) disable iff (reset)
        irq == |(status & mask)) else $error("irq level mismatch");
    a_event_sticky: assert property (@(posedge mclk) disable iff (reset)
        ib.events[0] |=> status[0]) else $error("event lost");
endmodule

// >>> pso_power_ctrl_tb_top.sv
// Self-checking testbench of the power and serial option control block.
// Assumes pso_pkg and the design files are compiled first; APB master on mclk.
`timescale 1ns/10ps
module pso_power_ctrl_tb_top;
    import pso_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    logic              mclk = 1'b0;             // Core clock
    logic              reset = 1'b1;            // Warm reset
    logic              cold_reset = 1'b1;       // Power-on reset
    logic              psel = 1'b0;             // APB select
    logic              penable = 1'b0;          // APB enable
    logic              pwrite = 1'b0;           // APB direction
    logic [PSO_AW-1:0] paddr = '0;              // APB address
    logic [PSO_DW-1:0] pwdata = '0;             // APB write data
    logic [PSO_DW-1:0] prdata;                  // APB read data
    logic              pready, pslverr;         // APB answer
    logic              stop_bit_invalid = 1'b0; // Bad stop pulse
    logic              wake_event = 1'b0;       // Wake pulse
    logic              power_down, baud_rate_x2, framing_error, irq; // Status outputs
    logic [7:0]        serial_control;          // Serial control bits
    int                error_cnt = 0;           // Mismatches
    int                compares = 0;            // Comparisons
    int                seed = 32'ha7ec;         // Random seed
    int                bd, sel, poff, gp, pd, sc, mode0, ferr, st, mk; // Behavioural model
    ////////////////////////////////////////////////////////////////////////////////
    // Device under test
    pso_power_ctrl pso_power_ctrl_inst (.mclk(mclk), .reset(reset), .cold_reset(cold_reset),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_bit_invalid(stop_bit_invalid), .wake_event(wake_event),
        .power_down(power_down), .baud_rate_x2(baud_rate_x2),
        .serial_control(serial_control), .framing_error(framing_error), .irq(irq));
    // Free-running clock, 4 ns period
    always #2 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected read data from the model
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        case (a)
            PSO_PWR_CTRL:   return 32'((bd << PSO_BAUD_DBL) | (sel << PSO_FRAME_SEL) |
                (poff << PSO_PWR_OFF) | (gp << PSO_GP_LO) | (pd << PSO_PD));
            PSO_SER_CTRL:   return 32'(((sel != 0 ? ferr : mode0) << PSO_SC_BIT7) | sc);
            PSO_IRQ_STATUS: return 32'(st);
            PSO_IRQ_MASK:   return 32'(mk);
            default:        return 32'h0;
        endcase
    endfunction
    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // No cycle limit here; only the watchdog ends a hang
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(32'(e), 32'(a > PSO_IRQ_MASK));
        chk(32'(n), 32'h2); // Access phase lasts two cycles
    endtask
    // Register write with model update
    task automatic wr(input logic [11:0] a, input int d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, 32'(d), r, e);
        case (a)
            PSO_PWR_CTRL: begin
                bd   = d[PSO_BAUD_DBL];
                sel  = d[PSO_FRAME_SEL];
                poff = d[PSO_PWR_OFF];
                gp   = d[PSO_GP_HI:PSO_GP_LO];
                if (d[PSO_PD]) begin
                    pd = 1;
                    st = st | (1 << PSO_IRQ_PD);
                end
            end
            PSO_SER_CTRL: begin
                sc = d[6:0];
                if (sel != 0) begin
                    ferr = d[PSO_SC_BIT7];
                end else begin
                    mode0 = d[PSO_SC_BIT7];
                end
            end
            PSO_IRQ_STATUS: st = st & ~d[1:0];
            PSO_IRQ_MASK:   mk = d[1:0];
            default: ;
        endcase
    endtask
    // Register read compared with model
    task automatic rd(input logic [11:0] a);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp_rd(a));
    endtask
    // Output levels compared with model once settled
    task automatic outs();
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(power_down), 32'(pd));
        chk(32'(baud_rate_x2), 32'(bd != 0 && (mode0 != 0 || sc[6])));
        chk(32'(serial_control), 32'((mode0 << 7) | sc));
        chk(32'(framing_error), 32'(ferr));
        chk(32'(irq), 32'((st & mk) != 0));
    endtask
    // Model state after a warm reset; the power-off flag is kept
    task automatic warm_model();
        bd    = 0;
        sel   = 0;
        gp    = 0;
        pd    = 0;
        sc    = 0;
        mode0 = 0;
        ferr  = 0;
        st    = 0;
        mk    = 0;
    endtask
    // Pulse an input for one cycle
    task automatic pulse(input int which);
        @(posedge mclk);
        if (which == 0) begin
            stop_bit_invalid <= 1'b1;
        end else begin
            wake_event <= 1'b1;
        end
        @(posedge mclk);
        stop_bit_invalid <= 1'b0;
        wake_event       <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short
    initial begin
        #80000;
        error_cnt++;
        close_out();
    end
    // Main sequence
    initial begin
        poff = 1;
        warm_model();
        repeat (6) @(posedge mclk);
        reset      <= 1'b0;
        cold_reset <= 1'b0;
        rd(PSO_PWR_CTRL);
        rd(PSO_SER_CTRL);
        rd(PSO_IRQ_STATUS);
        rd(PSO_IRQ_MASK);
        rd(12'h010);
        wr(12'h020, 32'hff);
        outs();
        // Flags store random values
        for (int i = 0; i < 4; i++) begin
            wr(PSO_PWR_CTRL, $random(seed) & 32'h1c);
            rd(PSO_PWR_CTRL);
        end
        // Baud doubling over every serial mode
        for (int m = 0; m < 8; m++) begin
            wr(PSO_SER_CTRL, ((m & 3) << 6) | ($random(seed) & 32'h3f));
            wr(PSO_PWR_CTRL, (m >> 2) << 7);
            outs();
            rd(PSO_SER_CTRL);
        end
        // Framing flag hidden, then visible through the select bit
        wr(PSO_PWR_CTRL, 0);
        wr(PSO_SER_CTRL, 0);
        pulse(0);
        ferr = 1;
        st   = st | (1 << PSO_IRQ_FRAME);
        outs();
        rd(PSO_SER_CTRL);
        wr(PSO_PWR_CTRL, 32'h40);
        rd(PSO_SER_CTRL);
        outs();
        wr(PSO_IRQ_MASK, 3);
        outs();
        wr(PSO_SER_CTRL, 32'h05);
        rd(PSO_SER_CTRL);
        wr(PSO_IRQ_STATUS, 1);
        outs();
        // Power-down entry and wake
        wr(PSO_PWR_CTRL, 32'h02);
        outs();
        rd(PSO_PWR_CTRL);
        rd(PSO_IRQ_STATUS);
        pulse(1);
        pd = 0;
        outs();
        wr(PSO_IRQ_STATUS, 2);
        outs();
        // Warm reset keeps the power-off flag
        for (int p = 0; p < 2; p++) begin
            wr(PSO_PWR_CTRL, (p << 4) | 32'hcc);
            @(posedge mclk);
            reset <= 1'b1;
            repeat (2) @(posedge mclk);
            reset <= 1'b0;
            warm_model();
            rd(PSO_PWR_CTRL);
            outs();
        end
        close_out();
    end
endmodule
